// file: hdl/cws_pkg.sv
`default_nettype none
package cws_pkg;
  // bus and storage shapes
  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;
  localparam int PAIR_W = 16;
  localparam int BUF_PAIRS = 12;
  localparam int IDX_W = 4;
  localparam int POS_W = 3;
  localparam int OUT_N = 6;
  // register offsets, byte addresses
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_LATCH = 8'h08;
  localparam logic [7:0] OFS_BUF_BASE = 8'h40;
  localparam logic [7:0] BUF_SPAN = 8'(BUF_PAIRS * 4);
  // control register fields
  localparam int CTRL_W = 10;
  localparam logic [9:0] CTRL_RESET = 10'h000;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_POSITION_COMPARE_ENABLE_BIT = 3;
  localparam int CTRL_EDGE_LSB = 4;
  localparam int CTRL_SEE_LSB = 6;
  localparam int CTRL_POSITION_DETECT_IRQ_ENABLE_BIT = 9;
  // status fields
  localparam int STAT_PDF_BIT = 0;
  localparam int STAT_POS_LSB = 1;
  // buffer pair word layout: bank, position code, six shape codes
  localparam int PAIR_BANK_BIT = 15;
  localparam int PAIR_CODE_LSB = 12;
  localparam logic [15:0] LATCH_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    MODE_SW_WRITE = 3'h0,
    MODE_UNDERFLOW = 3'h1,
    MODE_POS = 3'h2,
    MODE_POS_TIMER = 3'h3,
    MODE_POS_OR_TMR = 3'h4,
    MODE_POS_OR_TMR_B = 3'h5,
    MODE_POS_ONESHOT = 3'h6,
    MODE_POS_TMR_ONESHOT = 3'h7
  } cws_mode_e;

  typedef enum logic [1:0] {
    EDGE_NONE = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_BOTH = 2'h3
  } cws_edge_e;

  typedef enum logic [1:0] {
    SHAPE_LOW = 2'h0,
    SHAPE_PPG = 2'h1,
    SHAPE_PPG_INV = 2'h2,
    SHAPE_HIGH = 2'h3
  } cws_shape_e;

  // read path, gray along idle-fetch-load-resp
  typedef enum logic [1:0] {
    RD_IDLE = 2'h0,
    RD_FETCH = 2'h1,
    RD_LOAD = 2'h3,
    RD_RESP = 2'h2
  } cws_rd_state_e;

  // {hit, index} of a bus address inside the buffer window
  function automatic logic [4:0] bus_buf_idx(input logic [7:0] a);
    logic [7:0] off;
    off = a - OFS_BUF_BASE;
    bus_buf_idx = {(a >= OFS_BUF_BASE) && (off < BUF_SPAN) &&
                   (off[1:0] == 2'h0), off[5:2]};
  endfunction : bus_buf_idx

  // {valid, index} of the pair named by bank flag and position code
  function automatic logic [4:0] chain_idx(input logic [15:0] pair);
    chain_idx = {!pair[PAIR_BANK_BIT] || !pair[PAIR_CODE_LSB+2],
                 pair[PAIR_BANK_BIT], pair[PAIR_CODE_LSB +: 3]};
  endfunction : chain_idx

  // one waveform pin from its shape code
  function automatic logic shape_drive(input logic [1:0] s,
                                       input logic programmable_pulse_timer_output);
    case (cws_shape_e'(s))
      SHAPE_LOW: shape_drive = 1'b0;
      SHAPE_PPG: shape_drive = programmable_pulse_timer_output;
      SHAPE_PPG_INV: shape_drive = !programmable_pulse_timer_output;
      default: shape_drive = 1'b1;
    endcase
  endfunction : shape_drive
endpackage : cws_pkg
`default_nettype wire

// file: hdl/cws_buf_if.sv
`timescale 1ns/1ps
`default_nettype none
// buffer pair storage access between sequencer core and memory
interface cws_buf_if;
  import cws_pkg::*;
  logic wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [PAIR_W-1:0] wr_data;
  logic [1:0] wr_strb;
  logic [IDX_W-1:0] seq_idx;
  logic [PAIR_W-1:0] seq_data;
  logic [IDX_W-1:0] bus_idx;
  logic [PAIR_W-1:0] bus_data;
  modport core (output wr_en, wr_idx, wr_data, wr_strb, seq_idx, bus_idx,
                input seq_data, bus_data);
  modport mem (input wr_en, wr_idx, wr_data, wr_strb, seq_idx, bus_idx,
               output seq_data, bus_data);
endinterface : cws_buf_if
`default_nettype wire

// file: hdl/cws_pair_mem.sv
`timescale 1ns/1ps
`default_nettype none
module cws_pair_mem #(
  parameter int DEPTH = cws_pkg::BUF_PAIRS
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  cws_buf_if.mem port
);
  import cws_pkg::*;
  logic [PAIR_W-1:0] store [DEPTH];
  logic [PAIR_W-1:0] seq_data, bus_data, next_seq_data, next_bus_data;

  // byte-lane writes; no reset so it maps onto plain storage
  always_ff @(posedge clock_i) begin
    if (port.wr_en && (int'(port.wr_idx) < DEPTH)) begin
      if (port.wr_strb[0]) begin
        store[port.wr_idx][7:0] <= port.wr_data[7:0];
      end
      if (port.wr_strb[1]) begin
        store[port.wr_idx][15:8] <= port.wr_data[15:8];
      end
    end
  end

  // two registered read ports, out of range reads zero
  always_comb begin
    next_seq_data = '0;
    next_bus_data = '0;
    if (int'(port.seq_idx) < DEPTH) begin
      next_seq_data = store[port.seq_idx];
    end
    if (int'(port.bus_idx) < DEPTH) begin
      next_bus_data = store[port.bus_idx];
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      seq_data <= '0;
      bus_data <= '0;
    end else begin
      seq_data <= next_seq_data;
      bus_data <= next_bus_data;
    end
  end

  assign port.seq_data = seq_data;
  assign port.bus_data = bus_data;
endmodule : cws_pair_mem
`default_nettype wire

// file: hdl/cws_pos_sync.sv
`timescale 1ns/1ps
`default_nettype none
module cws_pos_sync #(
  parameter int WIDTH = cws_pkg::POS_W
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] rise_o,
  output logic [WIDTH-1:0] fall_o
);
  logic [WIDTH-1:0] meta, sync2, sync3, level, rise, fall;
  logic [WIDTH-1:0] next_level, next_rise, next_fall;

  // a level counts only once stages two and three agree
  always_comb begin
    next_level = level;
    for (int i = 0; i < WIDTH; i++) begin
      if (sync2[i] == sync3[i]) begin
        next_level[i] = sync3[i];
      end
    end
    next_rise = next_level & ~level;
    next_fall = ~next_level & level;
  end

  // meta is read by sync2 only
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta <= '0;
      sync2 <= '0;
      sync3 <= '0;
      level <= '0;
      rise <= '0;
      fall <= '0;
    end else begin
      meta <= pin_i;
      sync2 <= meta;
      sync3 <= sync2;
      level <= next_level;
      rise <= next_rise;
      fall <= next_fall;
    end
  end

  assign level_o = level;
  assign rise_o = rise;
  assign fall_o = fall;
endmodule : cws_pos_sync
`default_nettype wire

// file: hdl/cws_sequencer.sv
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module cws_sequencer (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [cws_pkg::AXI_AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [cws_pkg::AXI_DW-1:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [cws_pkg::AXI_AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [cws_pkg::AXI_DW-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [cws_pkg::POS_W-1:0] rotor_position_inputs_i,
  input wire logic programmable_pulse_timer_output_i,
  input wire logic timer_write_trigger_i,
  output logic timer_start_o,
  output logic [cws_pkg::OUT_N-1:0] waveform_output_o,
  output logic position_detect_irq_o
);
  import cws_pkg::*;

  cws_buf_if bufs();
  logic [POS_W-1:0] pos_level, pos_rise, pos_fall;

  cws_pair_mem #(.DEPTH(BUF_PAIRS)) u_mem (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .port(bufs.mem)
  );

  cws_pos_sync #(.WIDTH(POS_W)) u_sync (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(rotor_position_inputs_i),
    .level_o(pos_level),
    .rise_o(pos_rise),
    .fall_o(pos_fall)
  );

  // bus write side state
  logic aw_held, w_held, bvalid, awready, wready;
  logic next_aw_held, next_w_held, next_bvalid, next_awready, next_wready;
  logic [7:0] aw_addr, next_aw_addr;
  logic [15:0] w_data, next_w_data;
  logic [1:0] w_strb, next_w_strb, bresp, next_bresp;
  logic do_write, wr_ctrl, wr_stat, wr_ok, sw0;
  logic [4:0] wr_buf, rd_buf;
  // bus read side state
  cws_rd_state_e rd_state, next_rd_state;
  logic [7:0] ar_addr, next_ar_addr;
  logic arready, rvalid, next_arready, next_rvalid;
  logic [1:0] rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  // sequencer state
  logic [CTRL_W-1:0] ctrl, next_ctrl;
  logic [15:0] latch, next_latch;
  logic pdf, wto, xfer, tstart, os_done, irq;
  logic next_pdf, next_wto, next_xfer, next_tstart, next_os_done, next_irq;
  logic [OUT_N-1:0] wave, next_wave;
  cws_mode_e mode, mode_prev;
  cws_edge_e edge_sel;
  logic [POS_W-1:0] hits;
  logic trig, trig_raw, oneshot, xfer_ok;
  logic [4:0] chain;

  assign mode = cws_mode_e'(ctrl[CTRL_MODE_LSB +: 3]);
  assign edge_sel = cws_edge_e'(ctrl[CTRL_EDGE_LSB +: 2]);
  assign do_write = aw_held && w_held && !bvalid;
  assign wr_buf = bus_buf_idx(aw_addr);
  assign rd_buf = bus_buf_idx(ar_addr);

  // write address decode
  always_comb begin
    wr_ctrl = 1'b0;
    wr_stat = 1'b0;
    wr_ok = 1'b1;
    if (aw_addr == OFS_CTRL) begin
      wr_ctrl = 1'b1;
    end else if (aw_addr == OFS_STATUS) begin
      wr_stat = 1'b1;
    end else if (aw_addr == OFS_LATCH) begin
      wr_ok = 1'b1; // read-only, write dropped
    end else if (!wr_buf[IDX_W]) begin
      wr_ok = 1'b0;
    end
  end

  // full-word write to pair zero is the software write timing
  assign sw0 = do_write && (wr_buf == 5'h10) && (w_strb == 2'h3) &&
               (mode == MODE_SW_WRITE);
  assign bufs.wr_en = do_write && wr_buf[IDX_W];
  assign bufs.wr_idx = wr_buf[IDX_W-1:0];
  assign bufs.wr_data = w_data;
  assign bufs.wr_strb = w_strb;
  assign bufs.bus_idx = rd_buf[IDX_W-1:0];

  // address and data taken in either order, answered once both held
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    if (s_axi_awvalid_i && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata_i[15:0];
      next_w_strb = s_axi_wstrb_i[1:0];
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && s_axi_bready_i) begin
      next_bvalid = 1'b0;
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 16'h0000;
      w_strb <= 2'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      awready <= 1'b1;
      wready <= 1'b1;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      awready <= next_awready;
      wready <= next_wready;
    end
  end

  // reads wait one cycle for the registered buffer port
  always_comb begin
    next_rd_state = rd_state;
    next_ar_addr = ar_addr;
    next_arready = arready;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    case (rd_state)
      RD_IDLE: begin
        if (s_axi_arvalid_i && arready) begin
          next_ar_addr = s_axi_araddr_i;
          next_arready = 1'b0;
          next_rd_state = RD_FETCH;
        end
      end
      RD_FETCH: begin
        next_rd_state = RD_LOAD;
      end
      RD_LOAD: begin
        next_rvalid = 1'b1;
        next_rresp = RESP_OKAY;
        next_rdata = 32'h0;
        next_rd_state = RD_RESP;
        if (ar_addr == OFS_CTRL) begin
          next_rdata = 32'(ctrl);
        end else if (ar_addr == OFS_STATUS) begin
          next_rdata = 32'({pos_level, pdf});
        end else if (ar_addr == OFS_LATCH) begin
          next_rdata = 32'(latch);
        end else if (rd_buf[IDX_W]) begin
          next_rdata = 32'(bufs.bus_data);
        end else begin
          next_rresp = RESP_SLVERR;
        end
      end
      RD_RESP: begin
        if (s_axi_rready_i) begin
          next_rvalid = 1'b0;
          next_arready = 1'b1;
          next_rd_state = RD_IDLE;
        end
      end
      default: next_rd_state = RD_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_state <= RD_IDLE;
      ar_addr <= 8'h00;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= 32'h0;
    end else begin
      rd_state <= next_rd_state;
      ar_addr <= next_ar_addr;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  // position detector; code 00 never hits, prohibited under compare
  always_comb begin
    case (edge_sel)
      EDGE_RISE: hits = pos_rise;
      EDGE_FALL: hits = pos_fall;
      EDGE_BOTH: hits = pos_rise | pos_fall;
      default: hits = '0;
    endcase
    if (ctrl[CTRL_POSITION_COMPARE_ENABLE_BIT]) begin
      // any enabled edge launches the compare
      trig_raw = (|hits) && (pos_level == latch[PAIR_CODE_LSB +: 3]);
    end else begin
      trig_raw = |(hits & ctrl[CTRL_SEE_LSB +: 3]);
    end
    oneshot = (mode == MODE_POS_ONESHOT) || (mode == MODE_POS_TMR_ONESHOT);
    trig = trig_raw && !(oneshot && os_done);
  end

  // next pair comes from latch upper bits, pair zero in mode 000
  assign chain = chain_idx(latch);
  assign bufs.seq_idx = (mode == MODE_SW_WRITE) ? 4'h0 : chain[3:0];
  assign xfer_ok = (mode == MODE_SW_WRITE) || chain[4];

  // write timing source, transfer, flags and pins
  always_comb begin
    case (mode)
      MODE_SW_WRITE: next_wto = sw0;
      MODE_UNDERFLOW: next_wto = timer_write_trigger_i;
      MODE_POS, MODE_POS_ONESHOT: next_wto = trig;
      MODE_POS_TIMER, MODE_POS_TMR_ONESHOT: begin
        next_wto = timer_write_trigger_i;
      end
      default: next_wto = trig || timer_write_trigger_i;
    endcase
    next_tstart = trig && ((mode == MODE_POS_TIMER) ||
                           (mode == MODE_POS_TMR_ONESHOT));
    next_xfer = wto;
    next_latch = latch;
    if (xfer && xfer_ok) begin
      next_latch = bufs.seq_data;
    end
    // one-shot lock clears only when the mode moves
    next_os_done = os_done;
    if (mode != mode_prev) begin
      next_os_done = 1'b0;
    end else if (trig && oneshot) begin
      next_os_done = 1'b1;
    end
    next_ctrl = ctrl;
    if (do_write && wr_ctrl && w_strb[0]) begin
      next_ctrl[7:0] = w_data[7:0];
    end
    if (do_write && wr_ctrl && w_strb[1]) begin
      next_ctrl[CTRL_W-1:8] = w_data[CTRL_W-1:8];
    end
    // set beats a write-one clear in the same cycle
    next_pdf = pdf;
    if (trig) begin
      next_pdf = 1'b1;
    end else if (do_write && wr_stat && w_strb[0] && w_data[STAT_PDF_BIT]) begin
      next_pdf = 1'b0;
    end
    next_irq = next_pdf && ctrl[CTRL_POSITION_DETECT_IRQ_ENABLE_BIT];
    for (int i = 0; i < OUT_N; i++) begin
      next_wave[i] = shape_drive(latch[2*i +: 2],
                                 programmable_pulse_timer_output_i);
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl <= CTRL_RESET;
      latch <= LATCH_RESET;
      pdf <= 1'b0;
      wto <= 1'b0;
      xfer <= 1'b0;
      tstart <= 1'b0;
      os_done <= 1'b0;
      mode_prev <= MODE_SW_WRITE;
      irq <= 1'b0;
      wave <= '0;
    end else begin
      ctrl <= next_ctrl;
      latch <= next_latch;
      pdf <= next_pdf;
      wto <= next_wto;
      xfer <= next_xfer;
      tstart <= next_tstart;
      os_done <= next_os_done;
      mode_prev <= mode;
      irq <= next_irq;
      wave <= next_wave;
    end
  end

  assign s_axi_awready_o = awready;
  assign s_axi_wready_o = wready;
  assign s_axi_bvalid_o = bvalid;
  assign s_axi_bresp_o = bresp;
  assign s_axi_arready_o = arready;
  assign s_axi_rvalid_o = rvalid;
  assign s_axi_rresp_o = rresp;
  assign s_axi_rdata_o = rdata;
  assign timer_start_o = tstart;
  assign waveform_output_o = wave;
  assign position_detect_irq_o = irq;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_sw_write;
    (mode == MODE_SW_WRITE) && sw0;
  endsequence
  sequence s_load_path;
    wto ##1 xfer ##1 (latch == $past(w_data, 3));
  endsequence

  AST_IDLE_NO_TRIG:
    assert property ((mode == MODE_POS) && !ctrl[CTRL_POSITION_COMPARE_ENABLE_BIT] &&
      (ctrl[CTRL_SEE_LSB +: 3] == 3'h0) |=> !wto)
    else $error("edge trigger with all enables clear");
  AST_RISE_TRIG:
    assert property ((mode == MODE_POS) && !ctrl[CTRL_POSITION_COMPARE_ENABLE_BIT] &&
      (edge_sel == EDGE_RISE) && |(pos_rise & ctrl[CTRL_SEE_LSB +: 3])
      |=> wto)
    else $error("enabled rising edge gave no write timing");
  AST_CODE_NONE:
    assert property ((mode == MODE_POS) && (edge_sel == EDGE_NONE) |=> !wto)
    else $error("edge code none produced write timing");
  AST_CMP_MISMATCH:
    assert property ((mode == MODE_POS) && ctrl[CTRL_POSITION_COMPARE_ENABLE_BIT] &&
      (pos_level != latch[PAIR_CODE_LSB +: 3]) |=> !wto)
    else $error("compare mismatch produced write timing");
  AST_SW_WRITE:
    assert property (s_sw_write |=> s_load_path)
    else $error("buffer zero write did not reach latch");
  AST_UNDERFLOW:
    assert property ((mode == MODE_UNDERFLOW) && timer_write_trigger_i
      |=> wto)
    else $error("underflow missed write timing");
  AST_TIMER_START:
    assert property ((mode == MODE_POS_TIMER) && trig |=> timer_start_o)
    else $error("detection did not start timer");
  AST_OR_MODE:
    assert property ((mode == MODE_POS_OR_TMR) &&
      (trig || timer_write_trigger_i) |=> wto)
    else $error("either-source mode missed an event");
  AST_LATCH_CAUSE:
    assert property (!$stable(latch) |-> $past(xfer) && $past(wto, 2))
    else $error("latch changed without write timing");
  AST_PAIR_ZERO:
    assert property ((mode == MODE_SW_WRITE) |-> (bufs.seq_idx == 4'h0))
    else $error("mode 000 addressed a pair other than zero");
  AST_PD_FLAG:
    assert property (trig |=> pdf ##1 (position_detect_irq_o ==
      (pdf && $past(ctrl[CTRL_POSITION_DETECT_IRQ_ENABLE_BIT]))))
    else $error("detection flag or irq wrong");
endmodule : cws_sequencer
`default_nettype wire

// file: verif/cws_pos_timer_model.sv
`timescale 1ns/1ps
`default_nettype none
// rotor sensors plus a single-shot reload timer seen from the core
module cws_pos_timer_model #(
  parameter int DELAY = 20
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic timer_start_i,
  input wire logic sw_start_i,
  output logic [2:0] pos_o,
  output logic underflow_o,
  output int starts_o
);
  int cnt;
  initial pos_o = 3'h0;
  // timer starts from the core trigger or from software
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt <= 0;
      underflow_o <= 1'b0;
      starts_o <= 0;
    end else begin
      underflow_o <= (cnt == 1); // one-cycle underflow pulse
      if (timer_start_i || sw_start_i) begin
        cnt <= DELAY;
        starts_o <= starts_o + int'(timer_start_i);
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
  // sensor pins move off the clock edge, like a real async source
  task automatic set_pos(input logic [2:0] v);
    @(negedge clock_i);
    pos_o = v;
  endtask : set_pos
endmodule : cws_pos_timer_model
`default_nettype wire

// file: verif/commutation_write_timing_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module commutation_write_timing_sequencer_tb_top;
  import cws_pkg::*;
  `define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin \
    failures++; $display("[FAIL] %s exp %h got %h", nm, e, s); end end
  logic clk, rst, awv, wv, bry, arv, rry, programmable_pulse_timer_output, sws;
  logic awr, wr, bv, arr, rv, tst, irq, ufl;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd;
  logic [3:0] wst;
  logic [1:0] br, rr, resp;
  logic [2:0] pos;
  logic [5:0] wave;
  logic [31:0] v;
  int failures = 0, checks_done = 0, starts;
  always #2.5 clk = ~clk;
  cws_sequencer dut_u (.clock_i(clk), .sys_rst_i(rst), .s_axi_awaddr_i(awa),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(wst), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr),
    .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rry), .rotor_position_inputs_i(pos),
    .programmable_pulse_timer_output_i(programmable_pulse_timer_output), .timer_write_trigger_i(ufl),
    .timer_start_o(tst), .waveform_output_o(wave),
    .position_detect_irq_o(irq));
  cws_pos_timer_model pm_u (.clock_i(clk), .sys_rst_i(rst),
    .timer_start_i(tst), .sw_start_i(sws), .pos_o(pos),
    .underflow_o(ufl), .starts_o(starts));
  // ready sampled at the rising edge; a request drops only after its take
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic da, dw;
    da = 1'b0;
    dw = 1'b0;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    while (!(da && dw)) begin
      @(posedge clk);
      da = da | awr;
      dw = dw | wr;
      if (da) awv <= 1'b0;
      if (dw) wv <= 1'b0;
    end
    bry <= 1'b1;
    do @(posedge clk); while (!bv);
    resp = br;
    bry <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    rry <= 1'b1;
    do @(posedge clk); while (!rv);
    d = rd;
    resp = rr;
    rry <= 1'b0;
  endtask : axr
  // read the latch after a settle time longer than the pin path
  task automatic latch_is(input logic [15:0] e);
    repeat (14) @(posedge clk);
    axr(OFS_LATCH, v);
    `CHK("latch", {16'h0, e}, v)
  endtask : latch_is
  task automatic tmr;
    @(posedge clk) sws <= 1'b1;
    @(posedge clk) sws <= 1'b0;
    repeat (30) @(posedge clk);
  endtask : tmr
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  // a hang past the whole sequence ends the run
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_of_test();
  end
  initial begin
    clk = 1'b0;
    rst <= 1'b1;
    awv <= 1'b0;
    wv <= 1'b0;
    bry <= 1'b0;
    arv <= 1'b0;
    rry <= 1'b0;
    programmable_pulse_timer_output <= 1'b0;
    sws <= 1'b0;
    awa <= 8'h00;
    ara <= 8'h00;
    wd <= 32'h0;
    wst <= 4'hf;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    axr(OFS_CTRL, v);
    `CHK("ctrl", 32'h0, v)
    `CHK("wave", 6'h00, wave)
    axr(8'hfc, v);
    `CHK("resp", RESP_SLVERR, resp)
    axw(8'hfc, 32'h0);
    `CHK("bresp", RESP_SLVERR, resp)
    $display("test reset done");
    // a byte write to pair zero stores but must not transfer
    wst <= 4'h2;
    axw(OFS_BUF_BASE, 32'h4300);
    latch_is(16'h0000);
    wst <= 4'hf;
    axw(OFS_BUF_BASE, 32'h43c9);
    latch_is(16'h43c9);
    `CHK("wave0", 6'h1a, wave)
    programmable_pulse_timer_output <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("wave1", 6'h19, wave)
    axw(OFS_BUF_BASE + 8'h10, 32'h6003);
    axw(OFS_BUF_BASE + 8'h18, 32'h2f00);
    axw(OFS_BUF_BASE + 8'h08, 32'h8ccc);
    axw(OFS_BUF_BASE + 8'h20, 32'h0005);
    latch_is(16'h43c9);
    $display("test software write done");
    axw(OFS_CTRL, 32'h002);
    pm_u.set_pos(3'h1);
    latch_is(16'h43c9);
    pm_u.set_pos(3'h0);
    axw(OFS_CTRL, 32'h252);
    pm_u.set_pos(3'h1);
    latch_is(16'h6003);
    `CHK("irq", 1'b1, irq)
    pm_u.set_pos(3'h0);
    latch_is(16'h6003);
    axr(OFS_STATUS, v);
    `CHK("status", 32'h1, v)
    axw(OFS_STATUS, 32'h1);
    `CHK("bresp", RESP_OKAY, resp)
    $display("test edge detect done");
    axw(OFS_CTRL, 32'h001);
    tmr();
    latch_is(16'h2f00);
    tmr();
    latch_is(16'h8ccc);
    $display("test underflow done");
    axw(OFS_CTRL, 32'h03b);
    pm_u.set_pos(3'h2);
    latch_is(16'h8ccc);
    pm_u.set_pos(3'h0);
    repeat (30) @(posedge clk);
    `CHK("starts", 1, starts)
    latch_is(16'h0005);
    $display("test compare and timer done");
    axw(OFS_CTRL, 32'h114);
    pm_u.set_pos(3'h4);
    latch_is(16'h43c9);
    tmr();
    latch_is(16'h6003);
    $display("test either source done");
    // one-shot: first rising edge on pin 0 transfers, a later one must not
    axw(OFS_CTRL, 32'h056);
    pm_u.set_pos(3'h5);
    latch_is(16'h2f00);
    pm_u.set_pos(3'h4);
    latch_is(16'h2f00);
    pm_u.set_pos(3'h5);
    latch_is(16'h2f00);
    $display("test one-shot done");
    end_of_test();
  end
endmodule : commutation_write_timing_sequencer_tb_top
`default_nettype wire
